//--- interrupt_wake_enable_logic.sv
// Wake enable mask that gates peripheral interrupts into one wake request
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mask decides which interrupts may wake from deep-sleep and power-down.
// - Bits 0,1,8,12,13 enable both serial, I2C, watchdog, brown-out wakes.
// - Bit 3 enables first async port wake; port must be synchronous slave.
// - Bit 4 enables second async port wake; port must be synchronous slave.
// - Bit 5 enables third async port wake; port must be synchronous slave.
// - Bit 15 enables self wake timer wake; cleared means no wake.
// - Defined bits reset to zero; reserved bits read zero, no function.
module interrupt_wake_enable_logic (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [31:0] RDATA,
  input wire logic [1:0] POWER_MODE,
  input wire logic SERIAL_PERIPH_ZERO_IRQ,
  input wire logic SERIAL_PERIPH_ONE_IRQ,
  input wire logic ASYNC_PORT_ZERO_IRQ,
  input wire logic ASYNC_PORT_ONE_IRQ,
  input wire logic ASYNC_PORT_TWO_IRQ,
  input wire logic I2C_IRQ,
  input wire logic WINDOWED_WATCHDOG_IRQ,
  input wire logic BROWNOUT_IRQ,
  input wire logic SELF_WAKE_TIMER_IRQ,
  output logic WAKE_REQUEST,
  output logic [31:0] WAKE_ENABLE
);

  wake_enable_pkg::reg_req_type req;
  logic hit;
  logic [31:0] mask_value;
  logic [31:0] reg_rdata;
  logic [15:0] irq_vec;
  logic low_power;
  logic wake_r;
  logic wake_nxt;

  assign req = '{addr: ADDR, wdata: WDATA, write: WRITE, read: READ};
  assign hit = (req.addr == wake_enable_pkg::PERIPHERAL_WAKE_ENABLE_ADDR);

  wake_enable_reg #(
    .WIDTH(32)
  ) u_mask (
    .clock(CLOCK),
    .rst_n(RST_N),
    .wr_en(req.write && hit),
    .wr_data(req.wdata),
    .wr_mask(wake_enable_pkg::WAKE_ENABLE_MASK),
    .rd_en(req.read && hit),
    .value(mask_value),
    .rd_data(reg_rdata)
  );

  always_comb begin
    irq_vec = '0;
    irq_vec[wake_enable_pkg::SERIAL_PERIPH_ZERO_BIT] = SERIAL_PERIPH_ZERO_IRQ;
    irq_vec[wake_enable_pkg::SERIAL_PERIPH_ONE_BIT] = SERIAL_PERIPH_ONE_IRQ;
    irq_vec[wake_enable_pkg::ASYNC_PORT_ZERO_BIT] = ASYNC_PORT_ZERO_IRQ;
    irq_vec[wake_enable_pkg::ASYNC_PORT_ONE_BIT] = ASYNC_PORT_ONE_IRQ;
    irq_vec[wake_enable_pkg::ASYNC_PORT_TWO_BIT] = ASYNC_PORT_TWO_IRQ;
    irq_vec[wake_enable_pkg::I2C_BIT] = I2C_IRQ;
    irq_vec[wake_enable_pkg::WINDOWED_WATCHDOG_BIT] = WINDOWED_WATCHDOG_IRQ;
    irq_vec[wake_enable_pkg::BROWNOUT_BIT] = BROWNOUT_IRQ;
    irq_vec[wake_enable_pkg::SELF_WAKE_TIMER_BIT] = SELF_WAKE_TIMER_IRQ;
  end

  assign low_power = (POWER_MODE == wake_enable_pkg::MODE_DEEP_SLEEP) ||
                     (POWER_MODE == wake_enable_pkg::MODE_POWER_DOWN);

  always_comb begin
    wake_nxt = low_power && (|(irq_vec & mask_value[15:0]));
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // Read flop is zero outside mapped reads, so no mux follows it
  assign RDATA = reg_rdata;
  assign WAKE_REQUEST = wake_r;
  assign WAKE_ENABLE = mask_value;

  AST_WAKE_GATED: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wake_nxt |=> WAKE_REQUEST)
    else $error("wake request missed");

  AST_WAKE_DROPS: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !wake_nxt |=> !WAKE_REQUEST)
    else $error("wake request without enabled source");

  AST_NO_WAKE_RUN: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !low_power |=> !WAKE_REQUEST)
    else $error("wake outside low power");

  AST_RESERVED_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (mask_value & ~wake_enable_pkg::WAKE_ENABLE_MASK) == 32'h00000000)
    else $error("reserved bit set");

  AST_WRITE_TAKES: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (WRITE && hit) |=> (mask_value == ($past(WDATA) & wake_enable_pkg::WAKE_ENABLE_MASK)))
    else $error("write not stored");

  AST_MASK_HOLDS: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !(WRITE && hit) |=> $stable(mask_value))
    else $error("mask changed without a write");

  AST_READ_BACK: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (READ && hit) |=> (RDATA == $past(mask_value)))
    else $error("read data wrong");

  AST_RDATA_IDLE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !(READ && hit) |=> (RDATA == wake_enable_pkg::READ_UNMAPPED))
    else $error("read data outside a mapped read");

  AST_SERIAL_ZERO_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && SERIAL_PERIPH_ZERO_IRQ &&
     mask_value[wake_enable_pkg::SERIAL_PERIPH_ZERO_BIT]) |=> WAKE_REQUEST)
    else $error("serial port zero wake missed");

  AST_SERIAL_ONE_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && SERIAL_PERIPH_ONE_IRQ &&
     mask_value[wake_enable_pkg::SERIAL_PERIPH_ONE_BIT]) |=> WAKE_REQUEST)
    else $error("serial port one wake missed");

  AST_ASYNC_ZERO_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && ASYNC_PORT_ZERO_IRQ &&
     mask_value[wake_enable_pkg::ASYNC_PORT_ZERO_BIT]) |=> WAKE_REQUEST)
    else $error("async port zero wake missed");

  AST_ASYNC_ONE_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && ASYNC_PORT_ONE_IRQ &&
     mask_value[wake_enable_pkg::ASYNC_PORT_ONE_BIT]) |=> WAKE_REQUEST)
    else $error("async port one wake missed");

  AST_ASYNC_TWO_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && ASYNC_PORT_TWO_IRQ &&
     mask_value[wake_enable_pkg::ASYNC_PORT_TWO_BIT]) |=> WAKE_REQUEST)
    else $error("async port two wake missed");

  AST_I2C_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && I2C_IRQ &&
     mask_value[wake_enable_pkg::I2C_BIT]) |=> WAKE_REQUEST)
    else $error("bus unit wake missed");

  AST_WATCHDOG_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && WINDOWED_WATCHDOG_IRQ &&
     mask_value[wake_enable_pkg::WINDOWED_WATCHDOG_BIT]) |=> WAKE_REQUEST)
    else $error("watchdog wake missed");

  AST_BROWNOUT_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && BROWNOUT_IRQ &&
     mask_value[wake_enable_pkg::BROWNOUT_BIT]) |=> WAKE_REQUEST)
    else $error("brown-out wake missed");

  AST_TIMER_WAKE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (low_power && SELF_WAKE_TIMER_IRQ &&
     mask_value[wake_enable_pkg::SELF_WAKE_TIMER_BIT]) |=> WAKE_REQUEST)
    else $error("timer wake missed");

  AST_TIMER_OFF: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!mask_value[wake_enable_pkg::SELF_WAKE_TIMER_BIT] &&
     (irq_vec & mask_value[15:0]) == 16'h0000) |=> !WAKE_REQUEST)
    else $error("masked timer woke device");

  AST_RESET_CLEAR: assert property (@(posedge CLOCK)
    !RST_N |=> (mask_value == wake_enable_pkg::WAKE_ENABLE_RESET))
    else $error("mask not cleared by reset");

  AST_RESET_WAKE: assert property (@(posedge CLOCK)
    !RST_N |=> !WAKE_REQUEST)
    else $error("wake request not cleared by reset");

  // Main scenarios
  COV_WAKE: cover property (@(posedge CLOCK) disable iff (!RST_N) WAKE_REQUEST);
  COV_WRITE_READ: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (WRITE && hit) ##2 (READ && hit));
  COV_MASKED: cover property (@(posedge CLOCK) disable iff (!RST_N)
    low_power && (|irq_vec) && !wake_nxt);
  COV_DEEP_SLEEP_WAKE: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (POWER_MODE == wake_enable_pkg::MODE_DEEP_SLEEP) ##1 WAKE_REQUEST);
  COV_POWER_DOWN_WAKE: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (POWER_MODE == wake_enable_pkg::MODE_POWER_DOWN) ##1 WAKE_REQUEST);

endmodule
`default_nettype wire

//--- tb_interrupt_wake_enable_logic.sv
// Testbench for the interrupt wake enable logic
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_wake_enable_logic;
  localparam logic [31:0] A = wake_enable_pkg::PERIPHERAL_WAKE_ENABLE_ADDR;
  logic CLOCK, RST_N, WRITE, READ, WAKE_REQUEST;
  logic [31:0] ADDR, WDATA, RDATA, WAKE_ENABLE;
  logic [8:0] irq;
  logic [1:0] mode;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int pos [9] = '{0, 1, 3, 4, 5, 8, 12, 13, 15};
  wake_partner pm (.clock(CLOCK), .irq(irq), .mode(mode));
  interrupt_wake_enable_logic dut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .POWER_MODE(mode),
    .SERIAL_PERIPH_ZERO_IRQ(irq[0]), .SERIAL_PERIPH_ONE_IRQ(irq[1]),
    .ASYNC_PORT_ZERO_IRQ(irq[2]), .ASYNC_PORT_ONE_IRQ(irq[3]), .ASYNC_PORT_TWO_IRQ(irq[4]),
    .I2C_IRQ(irq[5]), .WINDOWED_WATCHDOG_IRQ(irq[6]), .BROWNOUT_IRQ(irq[7]),
    .SELF_WAKE_TIMER_IRQ(irq[8]), .WAKE_REQUEST(WAKE_REQUEST), .WAKE_ENABLE(WAKE_ENABLE));
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    WRITE <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WRITE <= 1'b0;
    @(negedge CLOCK);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge CLOCK);
    READ <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    READ <= 1'b0;
    @(negedge CLOCK);
    chk(e, RDATA);
  endtask
  task automatic wk(input logic [8:0] i, input logic [1:0] m, input logic e);
    pm.drive(i, m);
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk({31'h0, e}, {31'h0, WAKE_REQUEST});
  endtask
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    RST_N = 1'b0;
    WRITE = 1'b0;
    READ = 1'b0;
    ADDR = 32'h0;
    WDATA = 32'h0;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(negedge CLOCK);
    chk(32'h0, WAKE_ENABLE);
    rd(A, 32'h0);
    wr(A, 32'hFFFFFFFF);
    rd(A, 32'h0000B13B);
    wr(A + 32'h4, 32'h0);
    rd(A, 32'h0000B13B);
    rd(A + 32'h4, 32'h0);
    for (int k = 0; k < 9; k++) begin
      wr(A, 32'h1 << pos[k]);
      chk(32'h1 << pos[k], WAKE_ENABLE);
      wk(~(9'h1 << k), {1'b1, k[0]}, 1'b0);
      wk(9'h1 << k, {1'b1, k[0]}, 1'b1);
      wk(9'h1FF, 2'h0, 1'b0);
      wk(9'h1FF, 2'h1, 1'b0);
      wk(9'h000, 2'h3, 1'b0);
    end
    wk(9'h100, 2'h3, 1'b1);
    @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(negedge CLOCK);
    chk(32'h0, WAKE_ENABLE);
    chk(32'h0, {31'h0, WAKE_REQUEST});
    rd(A, 32'h0);
    wk(9'h100, 2'h3, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire

//--- wake_enable_pkg.sv
// Package: register map, field positions and types for the peripheral wake enable logic
`default_nettype none
package wake_enable_pkg;

  localparam logic [31:0] PERIPHERAL_WAKE_ENABLE_ADDR = 32'h40048214;
  localparam logic [31:0] WAKE_ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] WAKE_ENABLE_MASK = 32'h0000B13B;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

  localparam int SERIAL_PERIPH_ZERO_BIT = 0;
  localparam int SERIAL_PERIPH_ONE_BIT = 1;
  localparam int ASYNC_PORT_ZERO_BIT = 3;
  localparam int ASYNC_PORT_ONE_BIT = 4;
  localparam int ASYNC_PORT_TWO_BIT = 5;
  localparam int I2C_BIT = 8;
  localparam int WINDOWED_WATCHDOG_BIT = 12;
  localparam int BROWNOUT_BIT = 13;
  localparam int SELF_WAKE_TIMER_BIT = 15;

  localparam int SOURCE_COUNT = 16;
  localparam logic [1:0] POWER_MODE_RUN = 2'h0;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_POWER_DOWN
  } power_mode_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } reg_req_type;

endpackage
`default_nettype wire

//--- wake_enable_reg.sv
// Holds the wake enable mask word and returns it one cycle after a read
`timescale 1ns/1ps
`default_nettype none
module wake_enable_reg #(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] wr_mask,
  input wire logic rd_en,
  output logic [WIDTH-1:0] value,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] value_r;
  logic [WIDTH-1:0] value_nxt;
  logic [WIDTH-1:0] rd_data_r;
  logic [WIDTH-1:0] rd_data_nxt;

  always_comb begin
    value_nxt = value_r;
    rd_data_nxt = '0;
    if (wr_en) begin
      value_nxt = wr_data & wr_mask;
    end
    if (rd_en) begin
      rd_data_nxt = value_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      value_r <= '0;
      rd_data_r <= '0;
    end else begin
      value_r <= value_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign value = value_r;
  assign rd_data = rd_data_r;

endmodule
`default_nettype wire

//--- wake_partner.sv
// Far-side model: peripheral interrupt sources and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module wake_partner (
  input wire logic clock,
  output logic [8:0] irq,
  output logic [1:0] mode
);
  initial begin
    irq = 9'h000;
    mode = 2'h0;
  end
  // async ports sit as synchronous slaves
  // each source also enabled in core_interrupt_controller
  task automatic drive(input logic [8:0] i, input logic [1:0] m);
    @(posedge clock);
    irq <= i;
    mode <= m;
  endtask
endmodule
`default_nettype wire
